// [hw/pin_mux_pkg.sv]
// Shared constants for the two-port pin function multiplexer.
package pin_mux_pkg;
  localparam int PORT_W = 8;
  localparam int P2_PAD_W = 6;
  localparam int NUM_PORTS = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register offsets inside one port window, the two port bases, and the shared status and mask addresses.
  localparam logic [7:0] OFS_IN = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0c;
  localparam logic [7:0] OFS_EDGE = 8'h10;
  localparam logic [7:0] OFS_IE = 8'h14;
  localparam logic [7:0] OFS_SEL = 8'h18;
  localparam logic [7:0] PORT1_BASE = 8'h00;
  localparam logic [7:0] PORT2_BASE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_MASK = 8'h44;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] ST_RST = 2'h0;
  // Which bits have pads.
  localparam logic [7:0] P1_BONDED = 8'hff;
  localparam logic [7:0] P2_BONDED = 8'h3f;
  // Bit positions of the pins that feed on-chip inputs, and of the port 2 pin that the resistor select cuts off.
  localparam int P1_TCLK_BIT = 0;
  localparam int P1_CH0_BIT = 1;
  localparam int P1_CH1_BIT = 2;
  localparam int P1_CH2_BIT = 3;
  localparam int P2_ALT_BIT = 1;
  localparam int P2_CMP_BIT = 2;
  localparam int ROSC_BIT = 5;
  // Edge select encoding: 0 rising, 1 falling.
  localparam logic EDGE_FALLING = 1'b1;
  // Interrupt status layout and bus response codes.
  localparam int ST_W = 2;
  localparam int ST_P1 = 0;
  localparam int ST_P2 = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pin_mux_pkg

// [hw/pad_input_sync.sv]
// Two-stage pad synchroniser with rising and falling edge detection.
`timescale 1ns/10ps
module pad_input_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // The first stage only feeds the second, so metastability never reaches logic.
  // Reset keeps the stages sampling, so a pad that idles high shows no false edge once reset ends.
  always_ff @(posedge clk) begin
    if (!nrst || ce) begin
      meta_reg <= pad_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges are seen as the synchronised value against its one-cycle-old copy.
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule : pad_input_sync

// [hw/dual_port_pin_function_mux.sv]
// Two 8-bit general-purpose ports with peripheral function muxing and an AXI4-Lite register slave.
// Overview of operation
// - Direction bit 0 makes a pin an input; 1 lets it drive its pad.
// - Function select 0 drives the output latch; 1 drives the peripheral signal.
// - Port 1 bit 0 peripheral drives low and feeds the timer external clock.
// - Port 1 bits 1-3 drive timer channels 0-2 and feed capture inputs A.
// - Port 1 bit 4 drives sub-main clock; bits 5-7 drive timer channels 0-2.
// - Port 2 bit 0 drives auxiliary clock; bit 1 drives low, feeds alternate clock.
// - Port 2 bit 2 drives comparator result and feeds channel 0 capture B.
// - Port 2 bits 3 and 4 drive timer channels 1 and 2.
// - Port 2 bit 5 drives low; resistor select disconnects its pad entirely.
// - Port 2 bits 6 and 7 have no pads; only software changes their flags.
// - A bonded bit's flag is set by the pad edge its edge select picks.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module dual_port_pin_function_mux (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CE,
  // AXI4-Lite register slave.
  input wire logic [pin_mux_pkg::ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [pin_mux_pkg::DATA_W-1:0] WDATA,
  input wire logic [pin_mux_pkg::DATA_W/8-1:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [pin_mux_pkg::DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Pads.
  input wire logic [pin_mux_pkg::PORT_W-1:0] P1_PAD_IN,
  output logic [pin_mux_pkg::PORT_W-1:0] P1_PAD_OUT,
  output logic [pin_mux_pkg::PORT_W-1:0] P1_PAD_OE_N,
  input wire logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_IN,
  output logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_OUT,
  output logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_OE_N,
  // On-chip sources, same clock domain.
  input wire logic TIMER_CH0_OUTPUT,
  input wire logic TIMER_CH1_OUTPUT,
  input wire logic TIMER_CH2_OUTPUT,
  input wire logic SUB_MAIN_CLOCK,
  input wire logic AUX_CLOCK,
  input wire logic COMPARATOR_RESULT,
  input wire logic OSC_EXT_RESISTOR_SELECT,
  // On-chip sinks.
  output logic TIMER_EXT_CLOCK_IN,
  output logic TIMER_ALT_CLOCK_IN,
  output logic CH0_CAPTURE_IN_A,
  output logic CH1_CAPTURE_IN_A,
  output logic CH2_CAPTURE_IN_A,
  output logic CH0_CAPTURE_IN_B,
  // Interrupts.
  output logic PORT1_IRQ_REQUEST,
  output logic PORT2_IRQ_REQUEST,
  output logic IRQ
);
  import pin_mux_pkg::*;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bytes_t;

  // Port base address for a port index.
  function automatic logic [ADDR_W-1:0] port_base(input int p);
    port_base = (p == 0) ? PORT1_BASE : PORT2_BASE;
  endfunction : port_base

  // True when an address selects the given register of the given port.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input int p, input logic [7:0] ofs);
    reg_hit = (a == port_base(p) + ofs);
  endfunction : reg_hit

  // Register state.
  port_bytes_t out_latch_reg;
  port_bytes_t dir_reg;
  port_bytes_t flag_reg;
  port_bytes_t edge_reg;
  port_bytes_t ie_reg;
  port_bytes_t sel_reg;
  port_bytes_t flag_next;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] status_next;
  logic [ST_W-1:0] mask_reg;

  // Bus state.
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [PORT_W-1:0] wbyte_reg;
  logic wlane0_reg;
  logic wr_fire;
  logic wr_en;
  logic rd_fire;
  logic rd_clear;

  // Pad side state.
  port_bytes_t pad_out_reg;
  port_bytes_t pad_oe_n_reg;
  port_bytes_t in_val;
  port_bytes_t hw_set;
  port_bytes_t periph_out;
  port_bytes_t edge_ok;
  logic [PORT_W-1:0] p1_lvl;
  logic [PORT_W-1:0] p1_rise;
  logic [PORT_W-1:0] p1_fall;
  logic [P2_PAD_W-1:0] p2_lvl;
  logic [P2_PAD_W-1:0] p2_rise;
  logic [P2_PAD_W-1:0] p2_fall;
  logic [PORT_W-1:0] rosc_cut;
  logic ext_clk_reg;
  logic alt_clk_reg;
  logic cap0a_reg;
  logic cap1a_reg;
  logic cap2a_reg;
  logic cap0b_reg;
  logic [NUM_PORTS-1:0] port_req_reg;
  logic irq_reg;

  // Pad inputs come from outside the clock domain, so both ports pass a synchroniser.
  pad_input_sync #(.W(PORT_W)) p1_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .ce(CE),
    .pad_in(P1_PAD_IN),
    .level(p1_lvl),
    .rise(p1_rise),
    .fall(p1_fall)
  );

  pad_input_sync #(.W(P2_PAD_W)) p2_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .ce(CE),
    .pad_in(P2_PAD_IN),
    .level(p2_lvl),
    .rise(p2_rise),
    .fall(p2_fall)
  );

  // While the resistor select is set the pin 2.5 pad is cut off from all port logic.
  always_comb begin
    rosc_cut = '0;
    rosc_cut[ROSC_BIT] = OSC_EXT_RESISTOR_SELECT;
  end

  // Input values and qualified edges; unbonded bits never see a pad edge.
  always_comb begin
    in_val[0] = p1_lvl;
    in_val[1] = {{(PORT_W-P2_PAD_W){1'b0}}, p2_lvl} & ~rosc_cut;
    for (int b = 0; b < PORT_W; b++) begin
      edge_ok[0][b] = edge_reg[0][b] == EDGE_FALLING ? p1_fall[b] : p1_rise[b];
    end
    edge_ok[1] = '0;
    for (int b = 0; b < P2_PAD_W; b++) begin
      edge_ok[1][b] = edge_reg[1][b] == EDGE_FALLING ? p2_fall[b] : p2_rise[b];
    end
    hw_set[0] = edge_ok[0] & P1_BONDED;
    hw_set[1] = edge_ok[1] & P2_BONDED & ~rosc_cut;
  end

  // Peripheral output per bit; constant-low slots drive zero.
  always_comb begin
    periph_out[0] = {TIMER_CH2_OUTPUT, TIMER_CH1_OUTPUT, TIMER_CH0_OUTPUT, SUB_MAIN_CLOCK,
                     TIMER_CH2_OUTPUT, TIMER_CH1_OUTPUT, TIMER_CH0_OUTPUT, 1'b0};
    periph_out[1] = {1'b0, 1'b0, 1'b0, TIMER_CH2_OUTPUT, TIMER_CH1_OUTPUT,
                     COMPARATOR_RESULT, 1'b0, AUX_CLOCK};
  end

  // Write channel handshakes: address and data are taken in either order.
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_en = wr_fire & wlane0_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      wbyte_reg <= BYTE_RST;
      wlane0_reg <= 1'b0;
    end else if (CE) begin
      if (AWVALID && awready_reg) begin
        aw_addr_reg <= AWADDR;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (WVALID && wready_reg) begin
        wbyte_reg <= WDATA[PORT_W-1:0];
        wlane0_reg <= WSTRB[0];
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
      // Readiness returns only after the response, so one write is in flight at a time.
      if (bvalid_reg && BREADY) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Address map check shared by both channels.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_STATUS) || (a == OFS_MASK);
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (a >= port_base(p) && a <= port_base(p) + OFS_SEL && a[1:0] == WORD_ALIGN) begin
        mapped = 1'b1;
      end
    end
  endfunction : mapped

  // Plain control registers written by software.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      out_latch_reg <= '0;
      dir_reg <= '0;
      edge_reg <= '0;
      ie_reg <= '0;
      sel_reg <= '0;
      mask_reg <= ST_RST;
    end else if (CE && wr_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (reg_hit(aw_addr_reg, p, OFS_OUT)) out_latch_reg[p] <= wbyte_reg;
        if (reg_hit(aw_addr_reg, p, OFS_DIR)) dir_reg[p] <= wbyte_reg;
        if (reg_hit(aw_addr_reg, p, OFS_EDGE)) edge_reg[p] <= wbyte_reg;
        if (reg_hit(aw_addr_reg, p, OFS_IE)) ie_reg[p] <= wbyte_reg;
        if (reg_hit(aw_addr_reg, p, OFS_SEL)) sel_reg[p] <= wbyte_reg;
      end
      if (aw_addr_reg == OFS_MASK) mask_reg <= wbyte_reg[ST_W-1:0];
    end
  end

  // Flags: software writes replace the byte, and a same-cycle pad edge still wins.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      flag_next[p] = flag_reg[p];
      if (wr_en && reg_hit(aw_addr_reg, p, OFS_FLAG)) begin
        flag_next[p] = wbyte_reg;
      end
      flag_next[p] = flag_next[p] | hw_set[p];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      flag_reg <= '0;
    end else if (CE) begin
      flag_reg <= flag_next;
    end
  end

  // Read channel: data registered at the edge that takes the address, valid from the next cycle.
  assign rd_fire = ARVALID & arready_reg;
  assign rd_clear = rd_fire & (ARADDR == OFS_STATUS);

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (CE) begin
      if (rd_fire) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= {{(DATA_W-PORT_W){1'b0}}, read_byte(ARADDR)};
      end else if (rvalid_reg && RREADY) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Read multiplexer; unmapped addresses return zero.
  function automatic logic [PORT_W-1:0] read_byte(input logic [ADDR_W-1:0] a);
    read_byte = BYTE_RST;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (reg_hit(a, p, OFS_IN)) read_byte = in_val[p];
      if (reg_hit(a, p, OFS_OUT)) read_byte = out_latch_reg[p];
      if (reg_hit(a, p, OFS_DIR)) read_byte = dir_reg[p];
      if (reg_hit(a, p, OFS_FLAG)) read_byte = flag_reg[p];
      if (reg_hit(a, p, OFS_EDGE)) read_byte = edge_reg[p];
      if (reg_hit(a, p, OFS_IE)) read_byte = ie_reg[p];
      if (reg_hit(a, p, OFS_SEL)) read_byte = sel_reg[p];
    end
    if (a == OFS_STATUS) read_byte = {{(PORT_W-ST_W){1'b0}}, status_reg};
    if (a == OFS_MASK) read_byte = {{(PORT_W-ST_W){1'b0}}, mask_reg};
  endfunction : read_byte

  // Sticky status: a port's bit sets when a pad edge newly sets one of its flags; set beats the read-clear.
  always_comb begin
    status_next = rd_clear ? ST_RST : status_reg;
    status_next[ST_P1] = status_next[ST_P1] | (|(hw_set[0] & ~flag_reg[0]));
    status_next[ST_P2] = status_next[ST_P2] | (|(hw_set[1] & ~flag_reg[1]));
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      status_reg <= ST_RST;
      irq_reg <= 1'b0;
      port_req_reg <= '0;
    end else if (CE) begin
      status_reg <= status_next;
      irq_reg <= |(status_reg & mask_reg);
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_req_reg[p] <= |(flag_reg[p] & ie_reg[p]);
      end
    end
  end

  // Pad drive: register the mux so the pads never see combinational glitches.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pad_out_reg <= '0;
      pad_oe_n_reg <= '1;
    end else if (CE) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int b = 0; b < PORT_W; b++) begin
          pad_out_reg[p][b] <= sel_reg[p][b] ? periph_out[p][b] : out_latch_reg[p][b];
          pad_oe_n_reg[p][b] <= ~dir_reg[p][b];
        end
      end
      // A cut-off pin is neither driven nor read.
      if (OSC_EXT_RESISTOR_SELECT) begin
        pad_out_reg[1][ROSC_BIT] <= 1'b0;
        pad_oe_n_reg[1][ROSC_BIT] <= 1'b1;
      end
    end
  end

  // Pad values to the timer and clock units, only while the pin is in peripheral function.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      ext_clk_reg <= 1'b0;
      alt_clk_reg <= 1'b0;
      cap0a_reg <= 1'b0;
      cap1a_reg <= 1'b0;
      cap2a_reg <= 1'b0;
      cap0b_reg <= 1'b0;
    end else if (CE) begin
      ext_clk_reg <= sel_reg[0][P1_TCLK_BIT] & in_val[0][P1_TCLK_BIT];
      cap0a_reg <= sel_reg[0][P1_CH0_BIT] & in_val[0][P1_CH0_BIT];
      cap1a_reg <= sel_reg[0][P1_CH1_BIT] & in_val[0][P1_CH1_BIT];
      cap2a_reg <= sel_reg[0][P1_CH2_BIT] & in_val[0][P1_CH2_BIT];
      alt_clk_reg <= sel_reg[1][P2_ALT_BIT] & in_val[1][P2_ALT_BIT];
      cap0b_reg <= sel_reg[1][P2_CMP_BIT] & in_val[1][P2_CMP_BIT];
    end
  end

  // Outputs straight from flip-flops.
  assign AWREADY = awready_reg;
  assign WREADY = wready_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign ARREADY = arready_reg;
  assign RVALID = rvalid_reg;
  assign RRESP = rresp_reg;
  assign RDATA = rdata_reg;
  assign P1_PAD_OUT = pad_out_reg[0];
  assign P1_PAD_OE_N = pad_oe_n_reg[0];
  assign P2_PAD_OUT = pad_out_reg[1][P2_PAD_W-1:0];
  assign P2_PAD_OE_N = pad_oe_n_reg[1][P2_PAD_W-1:0];
  assign TIMER_EXT_CLOCK_IN = ext_clk_reg;
  assign TIMER_ALT_CLOCK_IN = alt_clk_reg;
  assign CH0_CAPTURE_IN_A = cap0a_reg;
  assign CH1_CAPTURE_IN_A = cap1a_reg;
  assign CH2_CAPTURE_IN_A = cap2a_reg;
  assign CH0_CAPTURE_IN_B = cap0b_reg;
  assign PORT1_IRQ_REQUEST = port_req_reg[0];
  assign PORT2_IRQ_REQUEST = port_req_reg[1];
  assign IRQ = irq_reg;
endmodule : dual_port_pin_function_mux

// [sim/pad_model.sv]
// Board-side pad model: each pad shows the port drive or the board level.
`timescale 1ns/10ps
module pad_model (
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [5:0] p2_out,
  input wire logic [5:0] p2_oe_n,
  input wire logic [7:0] p1_ext,
  input wire logic [5:0] p2_ext,
  output logic [7:0] p1_lvl,
  output logic [5:0] p2_lvl
);
  // A driving port wins; a released pad falls back to the board, so stale drive never lingers.
  always_comb begin
    p1_lvl = (p1_out & ~p1_oe_n) | (p1_ext & p1_oe_n);
    p2_lvl = (p2_out & ~p2_oe_n) | (p2_ext & p2_oe_n);
  end
endmodule : pad_model

// [sim/pin_mux_asserts.sv]
// Port-level checks for the two-port pin multiplexer.
`timescale 1ns/10ps
module pin_mux_asserts (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [pin_mux_pkg::DATA_W-1:0] RDATA,
  input wire logic RVALID,
  input wire logic [pin_mux_pkg::PORT_W-1:0] P1_PAD_IN,
  input wire logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_IN,
  input wire logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_OUT,
  input wire logic [pin_mux_pkg::P2_PAD_W-1:0] P2_PAD_OE_N,
  input wire logic OSC_EXT_RESISTOR_SELECT,
  input wire logic TIMER_EXT_CLOCK_IN,
  input wire logic TIMER_ALT_CLOCK_IN,
  input wire logic CH0_CAPTURE_IN_B,
  input wire logic IRQ
);
  import pin_mux_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // Bus answers come at fixed distances; the pad-fed inputs may lag the pad by two or three edges.
  a_write_lat: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer not on time");
  a_read_lat: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer not on time");
  a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped early");
  a_rdata_upper: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_resistor_cut: assert property (OSC_EXT_RESISTOR_SELECT |=> P2_PAD_OE_N[5] && !P2_PAD_OUT[5])
    else $error("resistor pin still driven");
  a_ext_clk_src: assert property (TIMER_EXT_CLOCK_IN |-> $past(P1_PAD_IN[0], 2) || $past(P1_PAD_IN[0], 3))
    else $error("timer clock high without pad");
  a_alt_clk_src: assert property (TIMER_ALT_CLOCK_IN |-> $past(P2_PAD_IN[1], 2) || $past(P2_PAD_IN[1], 3))
    else $error("alternate clock high without pad");
  a_cap_b_src: assert property (CH0_CAPTURE_IN_B |-> $past(P2_PAD_IN[2], 2) || $past(P2_PAD_IN[2], 3))
    else $error("capture input high without pad");
  c_slverr: cover property (BVALID && BRESP == RESP_SLVERR);
  c_irq: cover property ($rose(IRQ));
  c_cut: cover property ($rose(OSC_EXT_RESISTOR_SELECT));
endmodule : pin_mux_asserts
bind dual_port_pin_function_mux pin_mux_asserts u_asserts (.*);

// [sim/dual_port_pin_function_mux_bench.sv]
// Self-checking bench for the two-port pin multiplexer.
`timescale 1ns/10ps
module dual_port_pin_function_mux_bench;
  import pin_mux_pkg::*;
  logic CORE_CLK = 1'b0;
  logic NRST, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic IRQ, PORT1_IRQ_REQUEST, PORT2_IRQ_REQUEST, TIMER_EXT_CLOCK_IN, TIMER_ALT_CLOCK_IN;
  logic CH0_CAPTURE_IN_A, CH1_CAPTURE_IN_A, CH2_CAPTURE_IN_A, CH0_CAPTURE_IN_B;
  logic [7:0] AWADDR, ARADDR, P1_PAD_IN, P1_PAD_OUT, P1_PAD_OE_N, e1;
  logic [5:0] P2_PAD_IN, P2_PAD_OUT, P2_PAD_OE_N, e2;
  logic [31:0] WDATA, RDATA;
  logic [1:0] BRESP, RRESP;
  logic [6:0] src;
  int error_cnt = 0;
  int n_checks = 0;
  // Only the protection bits and strobes are tied off.
  dual_port_pin_function_mux DUT (.*, .AWPROT(3'h0), .ARPROT(3'h0), .WSTRB(4'hf),
    .TIMER_CH0_OUTPUT(src[0]), .TIMER_CH1_OUTPUT(src[1]), .TIMER_CH2_OUTPUT(src[2]), .SUB_MAIN_CLOCK(src[3]),
    .AUX_CLOCK(src[4]), .COMPARATOR_RESULT(src[5]), .OSC_EXT_RESISTOR_SELECT(src[6]));
  pad_model u_pads (.p1_out(P1_PAD_OUT), .p1_oe_n(P1_PAD_OE_N), .p2_out(P2_PAD_OUT), .p2_oe_n(P2_PAD_OE_N),
    .p1_ext(e1), .p2_ext(e2), .p1_lvl(P1_PAD_IN), .p2_lvl(P2_PAD_IN));
  // The core clock runs at 100 MHz.
  always #5 CORE_CLK = ~CORE_CLK;
  function automatic logic [7:0] exp_p1(input logic [6:0] s);
    return {s[2:0], s[3], s[2:0], 1'h0};
  endfunction : exp_p1
  function automatic logic [5:0] exp_p2(input logic [6:0] s);
    return {1'h0, s[2], s[1], s[5], 1'h0, s[4]};
  endfunction : exp_p2
  function automatic logic [7:0] ad(input int p, input logic [7:0] o);
    return (p != 0 ? PORT2_BASE : PORT1_BASE) + o;
  endfunction : ad
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, expv, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : tick
  // Address and data are offered together and each is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic pa, pw;
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    while (pa || pw) begin
      @(posedge CORE_CLK);
      pa = pa && !AWREADY;
      pw = pw && !WREADY;
      AWVALID <= pa;
      WVALID <= pw;
    end
    do @(posedge CORE_CLK); while (BVALID !== 1'h1);
    r = BRESP;
    BREADY <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do @(posedge CORE_CLK); while (ARREADY !== 1'h1);
    ARVALID <= 1'h0;
    do @(posedge CORE_CLK); while (RVALID !== 1'h1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
  endtask : rd
  task automatic wk(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", r, RESP_OKAY);
  endtask : wk
  task automatic rk(input string nm, input logic [7:0] a, input logic [31:0] expv);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, expv);
    chk("rresp", r, RESP_OKAY);
  endtask : rk
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // The whole run needs well under a thousand cycles, so this limit only trips on a hang.
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  // Main sequence.
  initial begin
    logic [1:0] r;
    logic [7:0] v, es, x;
    logic [31:0] d;
    logic [7:0] ofs [5] = '{OFS_OUT, OFS_DIR, OFS_EDGE, OFS_IE, OFS_SEL};
    NRST = 1'h0;
    CE = 1'h1;
    AWVALID = 1'h0;
    WVALID = 1'h0;
    BREADY = 1'h0;
    ARVALID = 1'h0;
    RREADY = 1'h0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    e1 = 8'h00;
    e2 = 6'h00;
    src = 7'h00;
    d = $urandom(89);
    tick(20);
    NRST <= 1'h1;
    tick(1);
    chk("oe_n_rst", {P1_PAD_OE_N, P2_PAD_OE_N}, 14'h3fff);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      foreach (ofs[k]) begin
        x = 8'($urandom);
        rk("reg_rst", ad(p, ofs[k]), 32'h0);
        wk(ad(p, ofs[k]), x);
        rk("reg_rw", ad(p, ofs[k]), {24'h000000, x});
      end
    end
    wr(8'h80, 8'h55, r);
    chk("bresp_bad", r, RESP_SLVERR);
    rd(8'h80, d, r);
    chk("rresp_bad", r, RESP_SLVERR);
    chk("rdata_bad", d, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      x = 8'($urandom);
      for (int p = 0; p < 2; p++) begin
        wk(ad(p, OFS_SEL), 8'h00);
        wk(ad(p, OFS_OUT), v);
        wk(ad(p, OFS_DIR), x);
      end
      tick(2);
      chk("p1_oe_n", P1_PAD_OE_N, 8'(~x));
      chk("p1_out", P1_PAD_OUT & x, v & x);
      chk("p2_oe_n", P2_PAD_OE_N, 6'(~x[5:0]));
      chk("p2_out", P2_PAD_OUT & x[5:0], v[5:0] & x[5:0]);
    end
    $display("test latch drive done");
    wk(ad(0, OFS_SEL), 8'hff);
    wk(ad(1, OFS_SEL), 8'hff);
    wk(ad(0, OFS_DIR), 8'hff);
    wk(ad(1, OFS_DIR), 8'hff);
    for (int i = 0; i < 8; i++) begin
      src <= 7'($urandom) & 7'h3f;
      tick(3);
      chk("p1_fn", P1_PAD_OUT, exp_p1(src));
      chk("p2_fn", P2_PAD_OUT, exp_p2(src));
      chk("fn_oe_n", {P1_PAD_OE_N, P2_PAD_OE_N}, 14'h0000);
    end
    // With the clock enable low the pads must keep the old peripheral values.
    CE <= 1'h0;
    src <= ~src & 7'h3f;
    tick(3);
    chk("ce_frozen", P1_PAD_OUT, exp_p1(~src));
    CE <= 1'h1;
    tick(2);
    chk("ce_run", P1_PAD_OUT, exp_p1(src));
    src[6] <= 1'h1;
    tick(2);
    chk("p25_cut", {P2_PAD_OE_N[5], P2_PAD_OUT[5]}, 2'h2);
    $display("test peripheral out done");
    wk(ad(0, OFS_DIR), 8'h00);
    wk(ad(1, OFS_DIR), 8'h00);
    for (int i = 0; i < 6; i++) begin
      e1 <= 8'($urandom);
      e2 <= 6'($urandom);
      tick(5);
      chk("ext_clk", TIMER_EXT_CLOCK_IN, e1[0]);
      chk("cap_a", {CH2_CAPTURE_IN_A, CH1_CAPTURE_IN_A, CH0_CAPTURE_IN_A}, e1[3:1]);
      chk("alt_clk", TIMER_ALT_CLOCK_IN, e2[1]);
      chk("cap_b", CH0_CAPTURE_IN_B, e2[2]);
      rk("p1_in", ad(0, OFS_IN), {24'h000000, e1});
      rk("p2_in", ad(1, OFS_IN), {27'h0, e2[4:0]});
    end
    src[6] <= 1'h0;
    $display("test peripheral in done");
    wk(ad(0, OFS_SEL), 8'h00);
    wk(ad(1, OFS_SEL), 8'h00);
    wk(ad(0, OFS_IE), 8'hff);
    wk(ad(1, OFS_IE), 8'h00);
    wk(OFS_MASK, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      es = (i == 0) ? 8'hff : 8'($urandom);
      e1 <= v;
      wk(ad(0, OFS_EDGE), es);
      tick(4);
      wk(ad(0, OFS_FLAG), 8'h00);
      rd(OFS_STATUS, d, r);
      e1 <= ~v;
      tick(5);
      x = ~(v ^ es);
      rk("flag", ad(0, OFS_FLAG), {24'h000000, x});
      chk("p1_req", PORT1_IRQ_REQUEST, |x);
      chk("irq_masked", IRQ, 1'h0);
      wk(OFS_MASK, 8'h01);
      tick(2);
      chk("irq", IRQ, |x);
      rk("status", OFS_STATUS, {31'h0, |x});
      tick(2);
      chk("irq_clr", IRQ, 1'h0);
      wk(OFS_MASK, 8'h00);
      wk(ad(0, OFS_FLAG), 8'h00);
      tick(2);
      chk("p1_req_clr", PORT1_IRQ_REQUEST, 1'h0);
    end
    $display("test edges done");
    wk(ad(1, OFS_IE), 8'hc0);
    wk(ad(1, OFS_FLAG), 8'hc0);
    tick(2);
    rk("sw_flag", ad(1, OFS_FLAG), 32'hc0);
    chk("p2_req", PORT2_IRQ_REQUEST, 1'h1);
    rk("sw_status", OFS_STATUS, 32'h0);
    wk(ad(1, OFS_FLAG), 8'h00);
    tick(2);
    chk("p2_req_clr", PORT2_IRQ_REQUEST, 1'h0);
    $display("test software flags done");
    results();
  end
endmodule : dual_port_pin_function_mux_bench
